// ---- design/break_ctrl.sv ----
/*
 * Break controller of the emulator: event, write-protect and timeout
 * breaks, the host register file on APB and the break interrupt.
 * Assumes the event trigger and protection flag come from logic on pclk,
 * and that the target wait pin is asynchronous to pclk.
 */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module break_ctrl #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Emulated processor bus
	input  wire logic              event_trigger,
	input  wire logic              cpu_wr,
	input  wire logic [ADDR_W-1:0] cpu_addr,
	input  wire logic              addr_protected,
	// Target system
	input  wire logic              target_wait_n,
	output logic                   target_wr,
	output logic [ADDR_W-1:0]      target_addr,
	// Break and interrupt
	output logic                   cpu_halt,
	output logic                   irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		break_pkg::run_state_e state;
		logic                  ev_en;
		logic                  wp_en;
		logic                  to_en;
		logic [15:0]           pass;
		logic [15:0]           remain;
		logic [3:0]            sticky;
		logic [3:0]            mask;
		logic [1:0]            cause;
		logic [31:0]           rdata;
		logic                  slverr;
		logic [1:0]            wait_sync;
	} ctrl_s;

	ctrl_s r;
	ctrl_s next_r;

	wait_watch_if ww ();

	logic        wr_acc;
	logic        rd_setup;
	logic        wp_hit;
	logic        ev_hit;
	logic        ev_break;
	logic        wp_break;
	logic        to_break;
	logic        running;
	logic [31:0] rd_val;
	logic        rd_ok;

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	wait_watch #(
		.LIMIT (break_pkg::WAIT_LIMIT)
	) u_watch (
		.pclk    (pclk),
		.presetn (presetn),
		.ww      (ww.watcher)
	);

	// Wait pin is active low; only the second sync stage is read.
	assign ww.enable  = r.to_en;
	assign ww.wait_on = ~r.wait_sync[1];

	// ------------------------------------------------------------
	// Bus and break conditions
	// ------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle.
	assign pready   = 1'b1;
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign running  = (r.state == break_pkg::ST_RUN);

	assign wp_hit      = cpu_wr & addr_protected;
	assign target_wr   = cpu_wr & ~addr_protected;
	assign target_addr = cpu_addr;

	assign ev_hit = event_trigger & r.ev_en & running;
	assign ev_break = ev_hit & (r.remain <= 16'h0001);
	assign wp_break = wp_hit & r.wp_en & running;
	assign to_break = ww.fire & running;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Read data is built in the setup cycle and held in a flop so that it
	// is stable across the whole access phase.
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (paddr)
			break_pkg::CTRL_OFS: begin
				rd_val[break_pkg::CTRL_EV_BIT]   = r.ev_en;
				rd_val[break_pkg::CTRL_WP_BIT]   = r.wp_en;
				rd_val[break_pkg::CTRL_TO_BIT]   = r.to_en;
				rd_val[break_pkg::CTRL_HALT_BIT] = ~running;
			end
			break_pkg::PASS_OFS: begin
				rd_val[15:0] = r.pass;
			end
			break_pkg::STATUS_OFS: begin
				rd_val[break_pkg::ST_WIDTH-1:0] = r.sticky;
			end
			break_pkg::MASK_OFS: begin
				rd_val[break_pkg::ST_WIDTH-1:0] = r.mask;
			end
			break_pkg::CAUSE_OFS: begin
				rd_val[1:0]   = r.cause;
				rd_val[31:16] = r.remain;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.wait_sync = {r.wait_sync[0], target_wait_n};

		// Register read capture and error flag for unmapped offsets.
		if (rd_setup) begin
			next_r.rdata  = rd_ok ? rd_val : 32'h0000_0000;
			next_r.slverr = ~rd_ok;
		end

		// Host writes; the resume bit only releases a halt.
		if (wr_acc) begin
			unique case (paddr)
				break_pkg::CTRL_OFS: begin
					next_r.ev_en = pwdata[break_pkg::CTRL_EV_BIT];
					next_r.wp_en = pwdata[break_pkg::CTRL_WP_BIT];
					next_r.to_en = pwdata[break_pkg::CTRL_TO_BIT];
					if (pwdata[break_pkg::CTRL_RESUME_BIT]) begin
						next_r.state = break_pkg::ST_RUN;
					end
				end
				break_pkg::PASS_OFS: begin
					if (pwdata[15:0] != 16'h0000) begin
						next_r.pass = pwdata[15:0];
						next_r.remain = pwdata[15:0];
					end
				end
				break_pkg::STATUS_OFS: begin
					next_r.sticky = r.sticky & ~pwdata[break_pkg::ST_WIDTH-1:0];
				end
				break_pkg::MASK_OFS: begin
					next_r.mask = pwdata[break_pkg::ST_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end

		if (ev_hit && !ev_break) begin
			next_r.remain = r.remain - 16'h0001;
		end

		// Event flags are applied after the clear so that a new event wins
		// over a host clear in the same cycle.
		if (ev_break) begin
			next_r.sticky[break_pkg::ST_EV_BIT] = 1'b1;
		end
		if (wp_break) begin
			next_r.sticky[break_pkg::ST_WP_BIT] = 1'b1;
		end
		if (to_break) begin
			next_r.sticky[break_pkg::ST_TO_BIT] = 1'b1;
		end
		if (wp_hit) begin
			next_r.sticky[break_pkg::ST_SUPP_BIT] = 1'b1;
		end

		// Any break halts; the halt also beats a resume in the same cycle.
		if (ev_break || wp_break || to_break) begin
			next_r.state = break_pkg::ST_HALT;
			next_r.remain = r.pass;
			if (wp_break) begin
				next_r.cause = break_pkg::CAUSE_WPROT;
			end else if (to_break) begin
				next_r.cause = break_pkg::CAUSE_TIMEOUT;
			end else begin
				next_r.cause = break_pkg::CAUSE_EVENT;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.state     <= break_pkg::ST_RUN;
			r.ev_en     <= break_pkg::EV_EN_RST;
			r.wp_en     <= break_pkg::WP_EN_RST;
			r.to_en     <= break_pkg::TO_EN_RST;
			r.pass      <= break_pkg::PASS_RST;
			r.remain    <= break_pkg::PASS_RST;
			r.sticky    <= 4'h0;
			r.mask      <= break_pkg::MASK_RST;
			r.cause     <= break_pkg::CAUSE_NONE;
			r.rdata     <= 32'h0000_0000;
			r.slverr    <= 1'b0;
			r.wait_sync <= 2'h3;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// A write to an unmapped offset also answers with an error.
	assign prdata   = r.rdata;
	assign pslverr  = psel & penable & (pwrite ? ~rd_ok : r.slverr);
	assign cpu_halt = ~running;
	assign irq      = |(r.sticky & r.mask);
endmodule
`default_nettype wire

// ---- common/break_pkg.sv ----
/*
 * Shared constants for the emulator break logic: APB register offsets,
 * field positions, reset values, cause codes and the wait limit.
 * Assumes a 32-bit APB with byte addresses and word-aligned registers.
 */
package break_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] PASS_OFS   = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS   = 8'h0C;
	localparam logic [7:0] CAUSE_OFS  = 8'h10;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_EV_BIT     = 0;
	localparam int CTRL_WP_BIT     = 1;
	localparam int CTRL_TO_BIT     = 2;
	localparam int CTRL_RESUME_BIT = 3;
	localparam int CTRL_HALT_BIT   = 8;

	// ------------------------------------------------------------
	// Status and mask fields, one sticky bit per event
	// ------------------------------------------------------------
	localparam int ST_EV_BIT   = 0;
	localparam int ST_WP_BIT   = 1;
	localparam int ST_TO_BIT   = 2;
	localparam int ST_SUPP_BIT = 3;
	localparam int ST_WIDTH    = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic        EV_EN_RST = 1'b0;
	localparam logic        WP_EN_RST = 1'b1;
	localparam logic        TO_EN_RST = 1'b1;
	localparam logic [15:0] PASS_RST  = 16'h0001;
	localparam logic [3:0]  MASK_RST  = 4'h0;

	// ------------------------------------------------------------
	// Cause codes and timing
	// ------------------------------------------------------------
	localparam logic [1:0] CAUSE_NONE    = 2'h0;
	localparam logic [1:0] CAUSE_EVENT   = 2'h1;
	localparam logic [1:0] CAUSE_WPROT   = 2'h2;
	localparam logic [1:0] CAUSE_TIMEOUT = 2'h3;
	localparam int         WAIT_LIMIT    = 128;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HALT = 2'b10
	} run_state_e;

endpackage

// ---- common/wait_watch_if.sv ----
/*
 * Carrier between the break controller and its wait watchdog.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface wait_watch_if;
	logic enable;   // Timeout break enabled.
	logic wait_on;  // Synchronised target wait, high while waiting.
	logic fire;     // One-cycle pulse: wait held too long.

	modport owner   (output enable, output wait_on, input fire);
	modport watcher (input enable, input wait_on, output fire);
endinterface
`default_nettype wire

// ---- design/wait_watch.sv ----
/*
 * Wait watchdog: counts consecutive cycles of target wait and pulses
 * once when the wait outlasts the limit.
 * Assumes the wait level is already synchronised to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module wait_watch #(
	parameter int LIMIT = break_pkg::WAIT_LIMIT
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Controller side
	wait_watch_if.watcher     ww
);
	typedef struct packed {
		logic [8:0] count;
		logic       fire;
	} watch_s;

	localparam logic [8:0] LIM = 9'(LIMIT);

	watch_s r;
	watch_s next_r;

	// Count only whole runs of wait; any gap or a disable restarts.
	always_comb begin
		next_r = r;
		next_r.fire = 1'b0;
		if (!ww.enable || !ww.wait_on) begin
			next_r.count = 9'h000;
		end else if (r.count != LIM + 9'h001) begin
			next_r.count = r.count + 9'h001;
			next_r.fire = (r.count == LIM);
		end
	end

	// State register; the count saturates so a stuck wait fires once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign ww.fire = r.fire;
endmodule
`default_nettype wire

// ---- test/target_sys.sv ----
/*
 * Target system model: holds the wait line low for a requested span and
 * counts the writes that reach its memory.
 * Assumes the bench pulses go for one cycle with hold_len already valid.
 */
`timescale 1ns/1ps
`default_nettype none
module target_sys (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bus from the break logic and bench control
	input  wire logic       target_wr,
	input  wire logic       go,
	input  wire logic [8:0] hold_len,
	// Wait pin and write tally
	output logic            target_wait_n,
	output logic [7:0]      wr_count
);
	// ------------------------------------------------------------
	// Wait span and memory writes
	// ------------------------------------------------------------
	logic [8:0] left;

	// The wait line idles high, as a pulled-up pin would.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left     <= 9'h000;
			wr_count <= 8'h00;
		end else begin
			left     <= go ? hold_len : (left != 9'h000 ? left - 9'h001 : 9'h000);
			wr_count <= wr_count + {7'h00, target_wr};
		end
	end
	assign target_wait_n = (left == 9'h000);
endmodule
`default_nettype wire

// ---- test/break_sva.sv ----
/*
 * Port checker for break_ctrl.
 * Assumes it is bound to every break_ctrl instance and sees ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module break_sva #(
	parameter int ADDR_W = 16
) (
	// Clock, reset and APB
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Processor and target side
	input wire logic              event_trigger,
	input wire logic              cpu_wr,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic              addr_protected,
	input wire logic              target_wait_n,
	input wire logic              target_wr,
	input wire logic [ADDR_W-1:0] target_addr,
	input wire logic              cpu_halt
);
	// ------------------------------------------------------------
	// Helpers and assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] wait_run;

	// Raw wait length, saturating so a stuck wait never wraps to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_run <= 8'h00;
		end else if (target_wait_n) begin
			wait_run <= 8'h00;
		end else if (wait_run != 8'hFF) begin
			wait_run <= wait_run + 8'h01;
		end
	end
	sequence resume_wr;
		psel && penable && pwrite && paddr == break_pkg::CTRL_OFS && pwdata[3];
	endsequence
	sequence halt_rise;
		$rose(cpu_halt);
	endsequence
	wr_suppress_a: assert property (target_wr == (cpu_wr && !addr_protected))
		else $error("protected write reached the target");
	addr_pass_a: assert property (target_addr == cpu_addr)
		else $error("target address differs from cpu address");
	zero_wait_a: assert property (psel && penable |-> pready)
		else $error("register access not answered");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("bus error outside access phase");
	unmapped_err_a: assert property (psel && penable && paddr == 8'h14 |-> pslverr)
		else $error("unmapped access not refused");
	// The wait pin is looked at four edges back: two sync stages, the fire
	// pulse and the halt register lie between pin and halt.
	halt_cause_a: assert property (halt_rise |-> $past(event_trigger) ||
		($past(cpu_wr) && $past(addr_protected)) || !$past(target_wait_n, 4))
		else $error("halt without a cause");
	halt_stay_a: assert property ($fell(cpu_halt) |-> $past(psel) && $past(penable) &&
		$past(pwrite) && $past(paddr) == break_pkg::CTRL_OFS &&
		$past(pwdata[break_pkg::CTRL_RESUME_BIT]))
		else $error("halt released without resume");
	// The run length is taken three edges back, so a wait released just
	// before the halt lands still counts.
	timeout_late_a: assert property (halt_rise ##0 !$past(event_trigger) ##0
		!($past(cpu_wr) && $past(addr_protected)) |-> $past(wait_run, 3) > 8'd128)
		else $error("timeout break too early");
	resume_c: cover property (resume_wr ##1 !cpu_halt);
endmodule
bind break_ctrl break_sva #(.ADDR_W(ADDR_W)) break_sva_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .event_trigger, .cpu_wr, .cpu_addr,
	.addr_protected, .target_wait_n, .target_wr, .target_addr, .cpu_halt);
`default_nettype wire

// ---- test/tb_top.sv ----
/*
 * Self-checking bench for break_ctrl with a target system model.
 * Assumes the checker binds itself and registers answer with no wait.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ------------------------------------------------------------
	// Signals, instances and shared tasks
	// ------------------------------------------------------------
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, wr_count;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, target_wait_n, target_wr, cpu_halt, irq;
	logic        event_trigger = 1'b0, cpu_wr = 1'b0, addr_protected = 1'b0, go = 1'b0;
	logic [15:0] cpu_addr = 16'h0123, target_addr;
	logic [8:0]  hold_len = 9'h000;
	int          failures = 0, n_checks = 0;

	break_ctrl break_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .event_trigger, .cpu_wr, .cpu_addr, .addr_protected,
		.target_wait_n, .target_wr, .target_addr, .cpu_halt, .irq);
	target_sys target_sys_i (.pclk, .presetn, .target_wr, .go, .hold_len, .target_wait_n,
		.wr_count);

	// Free-running 125 MHz clock.
	always #4 pclk = ~pclk;
	task finish_test;
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Whole APB transfer; the request holds until pready is seen high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// Outputs are looked at 1 ns after the edge so its updates have landed.
	task halt_chk(input logic exp);
		#1;
		check({31'h0, cpu_halt}, {31'h0, exp});
	endtask
	task irq_chk(input logic exp);
		#1;
		check({31'h0, irq}, {31'h0, exp});
	endtask
	task ev_pulse;
		@(posedge pclk);
		event_trigger <= 1'b1;
		@(posedge pclk);
		event_trigger <= 1'b0;
	endtask
	task cpu_write(input logic prot);
		@(posedge pclk);
		cpu_wr         <= 1'b1;
		addr_protected <= prot;
		cpu_addr       <= cpu_addr + 16'h1111;
		#1;
		check({31'h0, target_wr}, {31'h0, !prot});
		check({16'h0, target_addr}, {16'h0, cpu_addr});
		@(posedge pclk);
		cpu_wr <= 1'b0;
	endtask
	task stall(input logic [8:0] n);
		@(posedge pclk);
		go       <= 1'b1;
		hold_len <= n;
		@(posedge pclk);
		go <= 1'b0;
		repeat (n + 6) @(posedge pclk);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rchk(break_pkg::CTRL_OFS, 32'h0000_0006);
		rchk(break_pkg::PASS_OFS, 32'h0000_0001);
		rchk(break_pkg::CAUSE_OFS, 32'h0001_0000);
		apb(1'b0, 8'h14, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask
	task t_event;
		apb(1'b1, break_pkg::PASS_OFS, 32'h2);
		apb(1'b1, break_pkg::MASK_OFS, 32'h1);
		apb(1'b1, break_pkg::CTRL_OFS, 32'h7);
		ev_pulse;
		halt_chk(1'b0);
		ev_pulse;
		halt_chk(1'b1);
		irq_chk(1'b1);
		rchk(break_pkg::CAUSE_OFS, 32'h0002_0001);
		apb(1'b1, break_pkg::STATUS_OFS, 32'hF);
		irq_chk(1'b0);
		apb(1'b1, break_pkg::CTRL_OFS, 32'hE);
		halt_chk(1'b0);
		apb(1'b1, break_pkg::CTRL_OFS, 32'h6);
		repeat (3) ev_pulse;
		halt_chk(1'b0);
		// Disabled events must not count down; a zero pass count is ignored.
		rchk(break_pkg::CAUSE_OFS, 32'h0002_0001);
		apb(1'b1, break_pkg::PASS_OFS, 32'h0);
		rchk(break_pkg::PASS_OFS, 32'h0000_0002);
	endtask
	task t_prot;
		cpu_write(1'b1);
		halt_chk(1'b1);
		irq_chk(1'b0);
		rchk(break_pkg::CAUSE_OFS, 32'h0002_0002);
		rchk(break_pkg::STATUS_OFS, 32'h0000_000A);
		check({24'h0, wr_count}, 32'h0);
		apb(1'b1, break_pkg::STATUS_OFS, 32'hF);
		apb(1'b1, break_pkg::CTRL_OFS, 32'hE);
		apb(1'b1, break_pkg::CTRL_OFS, 32'h4);
		cpu_write(1'b1);
		halt_chk(1'b0);
		rchk(break_pkg::STATUS_OFS, 32'h8);
		apb(1'b1, break_pkg::MASK_OFS, 32'h8);
		irq_chk(1'b1);
		apb(1'b1, break_pkg::STATUS_OFS, 32'h8);
		irq_chk(1'b0);
		cpu_write(1'b0);
		#1; // The tally updates on the edge the task returns at.
		check({24'h0, wr_count}, 32'h1);
	endtask
	task t_timeout;
		stall(9'd128);
		halt_chk(1'b0);
		stall(9'd140);
		halt_chk(1'b1);
		rchk(break_pkg::CAUSE_OFS, 32'h0002_0003);
		rchk(break_pkg::STATUS_OFS, 32'h0000_0004);
		apb(1'b1, break_pkg::STATUS_OFS, 32'hF);
		apb(1'b1, break_pkg::CTRL_OFS, 32'h8);
		stall(9'd300);
		halt_chk(1'b0);
	endtask
	// Main sequence after a 20-cycle reset.
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_event;
		t_prot;
		t_timeout;
		finish_test;
	end
	// Watchdog well beyond the few hundred cycles the run needs.
	initial begin
		#200000;
		failures++;
		finish_test;
	end
endmodule
`default_nettype wire
